// *** hw/cvcw_decoder.sv ***
// Control word decoder for the cyclic synchronous velocity mode.
// Assumes cyclic writes arrive synchronous to sys_clk from the
// process-data front end, one strobe per written object.
//
// Summary of operation
// - Type bits 13..12 select sub-mode
// - Type change applies immediately
// - Halt bit 8 forces immediate stop
// - Type 00: position control, deviation alarms
// - Type 01: speed control, overload only
// - Type 10: push-motion, keep pressing load
// - Type 11 behaves as push-motion
// - Push holds 2.7 degree deviation
// - Target velocity signed, clamped to range
// - Velocity ignored flag and cases
module cvcw_decoder (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  cmd_wr,
  input  wire logic [15:0]           cmd_wdata,
  input  wire logic                  vel_wr,
  input  wire logic [31:0]           vel_wdata,
  input  wire cvcw_pkg::cvcw_core_t  core,
  output logic      [15:0]           cmd_rdata,
  output logic                       vel_accepted,
  output cvcw_pkg::cvcw_motion_t     motion,
  output logic                       alarm_overload,
  output logic                       alarm_deviation
);

  // ****************************************************************
  // Control word and target velocity
  // ****************************************************************
  logic [15:0]          cmd_q;
  logic [31:0]          vel_q;
  logic [31:0]          vel_clamped;
  cvcw_pkg::cvcw_type_t type_d;
  logic                 halt_d;
  logic                 ignore_d;
  cvcw_pkg::cvcw_state_t state_q;
  cvcw_pkg::cvcw_state_t state_d;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_q <= cvcw_pkg::CVCW_CMD_WORD_RST;
    end else if (cmd_wr) begin
      cmd_q <= cmd_wdata;
    end
  end

  cvcw_vel_clamp u_clamp (
    .vel_in  (vel_wdata),
    .vel_out (vel_clamped)
  );

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      vel_q <= 32'h0000_0000;
    end else if (vel_wr) begin
      vel_q <= vel_clamped;
    end
  end

  // Decode from the incoming word so a type change acts at once
  always_comb begin
    logic [15:0] w;
    w = cmd_wr ? cmd_wdata : cmd_q;
    // Only type and halt are decoded; other bits are dropped
    type_d = cvcw_pkg::cvcw_type_t'(
      w[cvcw_pkg::CVCW_TYPE_HI:cvcw_pkg::CVCW_TYPE_LO]);
    halt_d = w[cvcw_pkg::CVCW_HALT_BIT];
  end

  always_comb begin
    ignore_d = !core.op_enabled || !core.excited || halt_d ||
               core.stop_in || core.limit_active;
  end

  // ****************************************************************
  // Sub-mode state
  // ****************************************************************
  always_comb begin
    case (type_d)
      cvcw_pkg::CVCW_POS_CTRL: state_d = cvcw_pkg::CVCW_ST_POS;
      cvcw_pkg::CVCW_SPD_CTRL: state_d = cvcw_pkg::CVCW_ST_SPD;
      cvcw_pkg::CVCW_PUSH:     state_d = cvcw_pkg::CVCW_ST_PUSH;
      cvcw_pkg::CVCW_TORQUE:   state_d = cvcw_pkg::CVCW_ST_PUSH;
      default:                 state_d = cvcw_pkg::CVCW_ST_IDLE;
    endcase
    if (ignore_d) begin
      state_d = cvcw_pkg::CVCW_ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= cvcw_pkg::CVCW_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Motion commands
  // ****************************************************************
  logic        run_q;
  logic        imm_stop_q;
  logic        pos_ctrl_q;
  logic        spd_ctrl_q;
  logic        push_q;
  logic        dev_track_q;
  logic [15:0] push_dev_q;
  logic [31:0] velocity_q;

  // Run permission and halt
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      run_q      <= 1'b0;
      imm_stop_q <= 1'b0;
    end else begin
      run_q      <= !ignore_d;
      imm_stop_q <= halt_d;
    end
  end

  // ****************************************************************
  // Sub-mode selects
  // ****************************************************************
  // They follow the next state, so a type write acts at once
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pos_ctrl_q  <= 1'b0;
      spd_ctrl_q  <= 1'b0;
      push_q      <= 1'b0;
      dev_track_q <= 1'b0;
    end else begin
      pos_ctrl_q  <= (state_d == cvcw_pkg::CVCW_ST_POS);
      spd_ctrl_q  <= (state_d == cvcw_pkg::CVCW_ST_SPD);
      push_q      <= (state_d == cvcw_pkg::CVCW_ST_PUSH);
      dev_track_q <= (state_d == cvcw_pkg::CVCW_ST_POS);
    end
  end

  // Deviation held while pressing against a load
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      push_dev_q <= 16'h0000;
    end else if (state_d == cvcw_pkg::CVCW_ST_PUSH) begin
      push_dev_q <= cvcw_pkg::CVCW_PUSH_DEV_DDEG;
    end else begin
      push_dev_q <= 16'h0000;
    end
  end

  // ****************************************************************
  // Velocity toward the core
  // ****************************************************************
  // The stored velocity is kept while ignored, only the output is zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      velocity_q <= 32'h0000_0000;
    end else if (ignore_d) begin
      velocity_q <= 32'h0000_0000;
    end else if (vel_wr) begin
      velocity_q <= vel_clamped;
    end else begin
      velocity_q <= vel_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      vel_accepted <= 1'b0;
    end else begin
      vel_accepted <= !ignore_d;
    end
  end

  // ****************************************************************
  // Outputs from the command flops
  // ****************************************************************
  always_comb begin
    motion.run           = run_q;
    motion.imm_stop      = imm_stop_q;
    motion.pos_ctrl      = pos_ctrl_q;
    motion.spd_ctrl      = spd_ctrl_q;
    motion.push          = push_q;
    motion.dev_track     = dev_track_q;
    motion.push_dev_ddeg = push_dev_q;
    motion.velocity      = velocity_q;
  end

  // ****************************************************************
  // Alarms by sub-mode
  // ****************************************************************
  // Push and torque modes raise no alarm of their own
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      alarm_overload <= 1'b0;
    end else begin
      alarm_overload <= core.overload &&
                        ((state_q == cvcw_pkg::CVCW_ST_POS) ||
                         (state_q == cvcw_pkg::CVCW_ST_SPD));
    end
  end

  // Only position control watches the deviation
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      alarm_deviation <= 1'b0;
    end else begin
      alarm_deviation <= core.deviation_over &&
                         (state_q == cvcw_pkg::CVCW_ST_POS);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cmd_rdata <= cvcw_pkg::CVCW_CMD_WORD_RST;
    end else begin
      cmd_rdata <= cmd_wr ? cmd_wdata : cmd_q;
    end
  end

endmodule

// *** hw/cvcw_pkg.sv ***
// Package for the cyclic velocity control word decoder.
// Assumes a single 25 MHz system clock domain.
package cvcw_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [15:0] CVCW_CMD_WORD_IDX  = 16'h6040;
  localparam logic [15:0] CVCW_CMD_WORD_RST  = 16'h0000;
  localparam int          CVCW_TYPE_HI       = 13;
  localparam int          CVCW_TYPE_LO       = 12;
  localparam int          CVCW_HALT_BIT      = 8;
  localparam int          CVCW_VEL_IGN_BIT   = 12;
  localparam logic [31:0] CVCW_VEL_MAX       = 32'h003d0900;
  localparam logic [31:0] CVCW_VEL_MIN       = 32'hffc2f700;

  // ****************************************************************
  // Push-motion deviation figures, tenths of a degree
  // ****************************************************************
  localparam logic [15:0] CVCW_PUSH_DEV_DDEG = 16'h001b;
  localparam logic [15:0] CVCW_RETURN_DDEG   = 16'h0024;

  // ****************************************************************
  // Sub-modes of continuous operation
  // ****************************************************************
  typedef enum logic [1:0] {
    CVCW_POS_CTRL  = 2'h0,
    CVCW_SPD_CTRL  = 2'h1,
    CVCW_PUSH      = 2'h2,
    CVCW_TORQUE    = 2'h3
  } cvcw_type_t;

  // One-hot control state
  typedef enum logic [3:0] {
    CVCW_ST_IDLE  = 4'h1,
    CVCW_ST_POS   = 4'h2,
    CVCW_ST_SPD   = 4'h4,
    CVCW_ST_PUSH  = 4'h8
  } cvcw_state_t;

  // Conditions from the drive core
  typedef struct packed {
    logic op_enabled;
    logic excited;
    logic stop_in;
    logic limit_active;
    logic overload;
    logic deviation_over;
  } cvcw_core_t;

  // Commands toward the motion core
  typedef struct packed {
    logic        run;
    logic        imm_stop;
    logic        pos_ctrl;
    logic        spd_ctrl;
    logic        push;
    logic        dev_track;
    logic [15:0] push_dev_ddeg;
    logic [31:0] velocity;
  } cvcw_motion_t;

endpackage

// *** hw/cvcw_vel_clamp.sv ***
// Clamp of a signed 32-bit target velocity to the legal range.
// Purely combinational; used by the decoder top.
module cvcw_vel_clamp #(
  parameter logic [31:0] VMAX = cvcw_pkg::CVCW_VEL_MAX,
  parameter logic [31:0] VMIN = cvcw_pkg::CVCW_VEL_MIN
) (
  input  wire logic [31:0] vel_in,
  output logic      [31:0] vel_out
);

  always_comb begin
    if ($signed(vel_in) > $signed(VMAX)) begin
      vel_out = VMAX;
    end else if ($signed(vel_in) < $signed(VMIN)) begin
      vel_out = VMIN;
    end else begin
      vel_out = vel_in;
    end
  end

endmodule

// *** tb/cvcw_host_model.sv ***
// Main device model: cyclic writes of control word and velocity.
// Assumes the bench calls its tasks; it drives at falling edges.
module cvcw_host_model (
  input  wire logic        sys_clk,
  output logic             cmd_wr,
  output logic [15:0]      cmd_wdata,
  output logic             vel_wr,
  output logic [31:0]      vel_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
    vel_wr = 1'b0;
    vel_wdata = 32'h00000000;
  end
  // Released data shows the inverse, never the old value
  task automatic put_cmd(input logic [15:0] w);
    @(negedge sys_clk);
    cmd_wr = 1'b1;
    cmd_wdata = w;
    @(negedge sys_clk);
    cmd_wr = 1'b0;
    cmd_wdata = ~w;
  endtask
  // No push stop is issued, so no return move is owed
  task automatic put_vel(input logic [31:0] v);
    @(negedge sys_clk);
    vel_wr = 1'b1;
    vel_wdata = v;
    @(negedge sys_clk);
    vel_wr = 1'b0;
    vel_wdata = ~v;
  endtask
endmodule

// *** tb/cvcw_properties.sv ***
// Checker for the cyclic velocity control word decoder.
// Assumes it is bound to cvcw_decoder and sees only its ports.
module cvcw_properties (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   cmd_wr,
  input wire logic [15:0]            cmd_wdata,
  input wire logic                   vel_wr,
  input wire logic [31:0]            vel_wdata,
  input wire cvcw_pkg::cvcw_core_t   core,
  input wire logic [15:0]            cmd_rdata,
  input wire logic                   vel_accepted,
  input wire cvcw_pkg::cvcw_motion_t motion,
  input wire logic                   alarm_overload,
  input wire logic                   alarm_deviation
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire logic ok = core.op_enabled & core.excited & ~core.stop_in
                  & ~core.limit_active;
  sequence s_run_wr(logic [1:0] ty);
    cmd_wr && ok && !cmd_wdata[8] && cmd_wdata[13:12] == ty;
  endsequence
  AST_RDBACK: assert property (cmd_wr |=> cmd_rdata == $past(cmd_wdata))
    else $error("readback differs from written word");
  AST_HALT: assert property (cmd_wr && cmd_wdata[8] |=> motion.imm_stop
    && !motion.run && !vel_accepted && motion.velocity == 32'h0)
    else $error("halt did not stop");
  AST_POS: assert property (s_run_wr(2'h0)
    |=> motion.pos_ctrl && motion.run)
    else $error("position mode not entered");
  AST_SPD: assert property (s_run_wr(2'h1) |=> motion.spd_ctrl)
    else $error("speed mode not entered");
  AST_PUSH: assert property (cmd_wr && ok && !cmd_wdata[8]
    && cmd_wdata[13]
    |=> motion.push && motion.push_dev_ddeg == cvcw_pkg::CVCW_PUSH_DEV_DDEG)
    else $error("push mode not entered");
  AST_IGNORE: assert property (!ok |=> !vel_accepted && !motion.run)
    else $error("velocity used while ignored");
  AST_CLAMP: assert property (vel_wr && !cmd_wr && ok && !cmd_rdata[8]
    && $signed(vel_wdata) > $signed(cvcw_pkg::CVCW_VEL_MAX)
    |=> motion.velocity == cvcw_pkg::CVCW_VEL_MAX)
    else $error("velocity not clamped");
  AST_OVL: assert property (motion.spd_ctrl && $past(motion.spd_ctrl)
    && $past(core.overload) |-> alarm_overload && !alarm_deviation)
    else $error("speed mode alarm wrong");
  AST_DEV: assert property (motion.pos_ctrl && $past(motion.pos_ctrl)
    && $past(core.deviation_over) |-> alarm_deviation)
    else $error("deviation alarm missing");
endmodule

bind cvcw_decoder cvcw_properties i_props (.*);

// *** tb/cyclic_velocity_control_word_bench.sv ***
// Bench for the cyclic velocity control word decoder.
// Assumes the host model and the bound checker are compiled first.
module cyclic_velocity_control_word_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk, resetn, cmd_wr, vel_wr;
  logic                   vel_accepted, alarm_overload, alarm_deviation;
  logic [15:0]            cmd_wdata, cmd_rdata;
  logic [31:0]            vel_wdata;
  cvcw_pkg::cvcw_core_t   core;
  cvcw_pkg::cvcw_motion_t motion;
  int                     err_total = 0, samples_checked = 0, cyc = 0;
  logic [31:0]            vin [4] = '{32'h004c4b40, 32'hffb3b4c0,
                                      32'h003d0900, 32'h000004d2};
  logic [31:0]            vexp [4] = '{cvcw_pkg::CVCW_VEL_MAX,
                                       cvcw_pkg::CVCW_VEL_MIN,
                                       32'h003d0900, 32'h000004d2};
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  cvcw_host_model i_host (.sys_clk(sys_clk), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .vel_wr(vel_wr), .vel_wdata(vel_wdata));
  cvcw_decoder i_dut (.sys_clk(sys_clk), .resetn(resetn), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .vel_wr(vel_wr), .vel_wdata(vel_wdata),
    .core(core), .cmd_rdata(cmd_rdata), .vel_accepted(vel_accepted),
    .motion(motion), .alarm_overload(alarm_overload),
    .alarm_deviation(alarm_deviation));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    resetn = 1'b0;
    core = 6'h30;
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    for (int t = 0; t < 4; t++) begin
      i_host.put_cmd(16'hceff | 16'(t << 12));
      check(32'(cmd_rdata), 32'(16'hceff | 16'(t << 12)));
      check(32'({motion.pos_ctrl, motion.spd_ctrl, motion.push}),
            t == 0 ? 32'h4 : t == 1 ? 32'h2 : 32'h1);
      check(32'(motion.push_dev_ddeg),
            t > 1 ? 32'(cvcw_pkg::CVCW_PUSH_DEV_DDEG) : 32'h0);
      check(32'({motion.run, vel_accepted}), 32'h3);
      check(32'(motion.dev_track), t == 0 ? 32'h1 : 32'h0);
    end
    foreach (vin[i]) begin
      i_host.put_vel(vin[i]);
      check(motion.velocity, vexp[i]);
    end
    i_host.put_cmd(16'h0100);
    check(32'({motion.run, motion.imm_stop, vel_accepted}), 32'h2);
    check(motion.velocity, 32'h0);
    i_host.put_cmd(16'h1000);
    check(motion.velocity, 32'h000004d2);
    core = 6'h38;
    @(negedge sys_clk);
    check(32'(vel_accepted), 32'h0);
    core = 6'h32;
    repeat (3) @(negedge sys_clk);
    check(32'({alarm_overload, alarm_deviation}), 32'h2);
    core = 6'h31;
    i_host.put_cmd(16'h0000);
    repeat (2) @(negedge sys_clk);
    check(32'({alarm_overload, alarm_deviation}), 32'h1);
    resetn = 1'b0;
    @(negedge sys_clk);
    check(32'({cmd_rdata, vel_accepted, motion.run}), 32'h0);
    check(motion.velocity, 32'h0);
    resetn = 1'b1;
    @(negedge sys_clk);
    check(32'({motion.run, motion.pos_ctrl, vel_accepted}), 32'h7);
    check(32'(cmd_rdata), 32'h0);
    print_verdict();
  end
endmodule
